// *** design/art_regs.svh ***
// Purpose: Register offsets, field positions and counts for timer two
// Assumes: 32-bit APB, one register per aligned word
// Notes:   Offsets are byte addresses
`ifndef ART_REGS_SVH
`define ART_REGS_SVH
`define ART_OFS_CTRL      12'h000
`define ART_OFS_CNT_LO    12'h004
`define ART_OFS_CNT_HI    12'h008
`define ART_OFS_RLD_LO    12'h00C
`define ART_OFS_RLD_HI    12'h010
`define ART_OFS_CLKCFG    12'h014
`define ART_OFS_IRQ_STAT  12'h018
`define ART_OFS_IRQ_EN    12'h01C
`define ART_OFS_IRQ_CLR   12'h020
`define ART_BIT_HOVF      7
`define ART_BIT_LOVF      6
`define ART_BIT_LIEN      5
`define ART_BIT_SPLIT     3
`define ART_BIT_RUN       2
`define ART_BIT_XCLK      0
`define ART_BIT_FAST_LO   0
`define ART_BIT_FAST_HI   1
`define ART_CTRL_WMASK    8'hED
`define ART_DIV_SYS       12
`define ART_DIV_EXT       8
`endif

// *** design/art_pkg.sv ***
// Purpose: Types shared by the timer two design
// Assumes: Constants live in art_regs.svh
// Notes:   None
package art_pkg;
  typedef struct packed {
    logic       hovf;
    logic       lovf;
    logic       lien;
    logic       split;
    logic       run;
    logic       xclk;
  } art_ctrl_t;
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } art_word_t;
  typedef enum logic [1:0] {
    ART_IDLE   = 2'b00,
    ART_ACCESS = 2'b01
  } art_apb_t;
endpackage

// *** design/art_timer.sv ***
// Purpose: 16-bit or split 8-bit auto-reload timer behind APB
// Assumes: ext_osc is synchronous level input from external oscillator
// Notes:   Interrupt bit 0 high overflow, bit 1 low overflow (if enabled)
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`include "art_regs.svh"
module art_timer
(
  // Clock, reset, freeze
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // External oscillator and interrupt
  input  wire logic        ext_osc,
  output logic             irq
);
  art_pkg::art_ctrl_t ctrl_q, ctrl_d;
  art_pkg::art_word_t cnt_q, cnt_d, rld_q, rld_d;
  logic [1:0]  fast_q, fast_d;
  logic [1:0]  ien_q, ien_d, stat_q, stat_d;
  logic [3:0]  pre12_q, pre12_d;
  logic [2:0]  pre8_q, pre8_d;
  logic        ext_s1_q, ext_s2_q, ext_s3_q;
  logic        ext_tick_q, ext_tick_d;
  logic        pready_q, pready_d, irq_q, irq_d;
  logic [31:0] prdata_q, prdata_d;
  logic        slverr_q, slverr_d;
  logic        tick12, tick_lo, tick_hi, wr, rd;
  logic        lo_wrap, hi_wrap, lo_run, hi_run;

  // External clock is brought in through two flops, then edge found
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end
    else if (clk_en)
    begin
      ext_s1_q <= ext_osc;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // Prescalers: divide-by-12 of pclk and divide-by-8 of external edges
  always_comb
  begin
    tick12     = (pre12_q == 4'(`ART_DIV_SYS - 1));
    pre12_d    = tick12 ? 4'h0 : pre12_q + 4'h1;
    pre8_d     = pre8_q;
    ext_tick_d = 1'b0;
    if (ext_s2_q && !ext_s3_q)
    begin
      // Three bits so that every eighth edge ticks, not every fourth
      pre8_d     = pre8_q + 3'h1;
      ext_tick_d = (pre8_q == 3'(`ART_DIV_EXT - 1));
    end
  end

  // Per-half tick select
  always_comb
  begin
    tick_lo = fast_q[`ART_BIT_FAST_LO] ? 1'b1 :
              (ctrl_q.xclk ? ext_tick_q : tick12);
    tick_hi = fast_q[`ART_BIT_FAST_HI] ? 1'b1 :
              (ctrl_q.xclk ? ext_tick_q : tick12);
  end

  // APB decode: zero wait states, error on unmapped address
  assign wr = psel && penable && pwrite;
  // Setup phase of either direction; the answer is prepared here
  assign rd = psel && !penable;

  // Counter, reload, control and interrupt next state
  always_comb
  begin
    ctrl_d = ctrl_q;
    cnt_d  = cnt_q;
    rld_d  = rld_q;
    fast_d = fast_q;
    ien_d  = ien_q;
    stat_d = stat_q;
    lo_wrap = 1'b0;
    hi_wrap = 1'b0;
    // Software writes first, so that hardware events below win over clears
    if (wr)
    begin
      case (paddr)
        `ART_OFS_CTRL:
        begin
          ctrl_d.hovf  = pwdata[`ART_BIT_HOVF];
          ctrl_d.lovf  = pwdata[`ART_BIT_LOVF];
          ctrl_d.lien  = pwdata[`ART_BIT_LIEN];
          ctrl_d.split = pwdata[`ART_BIT_SPLIT];
          ctrl_d.run   = pwdata[`ART_BIT_RUN];
          ctrl_d.xclk  = pwdata[`ART_BIT_XCLK];
        end
        `ART_OFS_CNT_LO:  cnt_d.lo = pwdata[7:0];
        `ART_OFS_CNT_HI:  cnt_d.hi = pwdata[7:0];
        `ART_OFS_RLD_LO:  rld_d.lo = pwdata[7:0];
        `ART_OFS_RLD_HI:  rld_d.hi = pwdata[7:0];
        `ART_OFS_CLKCFG:  fast_d   = pwdata[1:0];
        `ART_OFS_IRQ_EN:  ien_d    = pwdata[1:0];
        `ART_OFS_IRQ_CLR: stat_d   = stat_q & ~pwdata[1:0];
        default: ;
      endcase
    end
    lo_run = ctrl_q.split ? tick_lo : (ctrl_q.run && tick_lo);
    hi_run = ctrl_q.split ? (ctrl_q.run && tick_hi) : 1'b0;
    if (!ctrl_q.split)
    begin
      if (lo_run)
      begin
        lo_wrap = (cnt_q.lo == 8'hFF);
        hi_wrap = lo_wrap && (cnt_q.hi == 8'hFF);
        if (hi_wrap)
          cnt_d = rld_q;
        else
          cnt_d = art_pkg::art_word_t'(cnt_q + 16'h0001);
      end
    end
    else
    begin
      if (lo_run)
      begin
        lo_wrap  = (cnt_q.lo == 8'hFF);
        cnt_d.lo = lo_wrap ? rld_q.lo : cnt_q.lo + 8'h01;
      end
      if (hi_run)
      begin
        hi_wrap  = (cnt_q.hi == 8'hFF);
        cnt_d.hi = hi_wrap ? rld_q.hi : cnt_q.hi + 8'h01;
      end
    end
    // Flags only set here; never cleared by hardware
    if (hi_wrap)
      ctrl_d.hovf = 1'b1;
    if (lo_wrap)
      ctrl_d.lovf = 1'b1;
    if (hi_wrap)
      stat_d[0] = 1'b1;
    if (lo_wrap && ctrl_q.lien)
      stat_d[1] = 1'b1;
  end

  // Read data and answer
  always_comb
  begin
    pready_d = rd;
    slverr_d = 1'b0;
    prdata_d = prdata_q;
    if (rd)
    begin
      prdata_d = 32'h0000_0000;
      case (paddr)
        `ART_OFS_CTRL:
          prdata_d[7:0] = {ctrl_q.hovf, ctrl_q.lovf, ctrl_q.lien, 1'b0,
                           ctrl_q.split, ctrl_q.run, 1'b0, ctrl_q.xclk};
        `ART_OFS_CNT_LO:   prdata_d[7:0] = cnt_q.lo;
        `ART_OFS_CNT_HI:   prdata_d[7:0] = cnt_q.hi;
        `ART_OFS_RLD_LO:   prdata_d[7:0] = rld_q.lo;
        `ART_OFS_RLD_HI:   prdata_d[7:0] = rld_q.hi;
        `ART_OFS_CLKCFG:   prdata_d[1:0] = fast_q;
        `ART_OFS_IRQ_STAT: prdata_d[1:0] = stat_q;
        `ART_OFS_IRQ_EN:   prdata_d[1:0] = ien_q;
        `ART_OFS_IRQ_CLR:  ;
        default:           slverr_d = 1'b1;
      endcase
    end
    irq_d = |(stat_d & ien_d);
  end

  // Register stage; clk_en low freezes everything
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q     <= '0;
      cnt_q      <= '0;
      rld_q      <= '0;
      fast_q     <= 2'h0;
      ien_q      <= 2'h0;
      stat_q     <= 2'h0;
      pre12_q    <= 4'h0;
      pre8_q     <= 3'h0;
      ext_tick_q <= 1'b0;
      pready_q   <= 1'b0;
      prdata_q   <= 32'h0000_0000;
      slverr_q   <= 1'b0;
      irq_q      <= 1'b0;
    end
    else if (clk_en)
    begin
      ctrl_q     <= ctrl_d;
      cnt_q      <= cnt_d;
      rld_q      <= rld_d;
      fast_q     <= fast_d;
      ien_q      <= ien_d;
      stat_q     <= stat_d;
      pre12_q    <= pre12_d;
      pre8_q     <= pre8_d;
      ext_tick_q <= ext_tick_d;
      pready_q   <= pready_d;
      prdata_q   <= prdata_d;
      slverr_q   <= slverr_d;
      irq_q      <= irq_d;
    end
  end

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = slverr_q;
  assign irq     = irq_q;

  // Checks
  wrap16_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !ctrl_q.split && ctrl_q.run && tick_lo && cnt_q == 16'hFFFF
    |=> cnt_q == $past(rld_q) && ctrl_q.hovf)
    else $error("16-bit wrap did not reload");
  flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q.hovf && !(wr && paddr == `ART_OFS_CTRL) |=> ctrl_q.hovf)
    else $error("high flag cleared by hardware");
  split_lo_free_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && ctrl_q.split && !ctrl_q.run && fast_q[0] && cnt_q.lo != 8'hFF
    && !wr |=> cnt_q.lo == $past(cnt_q.lo) + 8'h01)
    else $error("low half not free running");
  split_hi_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && ctrl_q.split && !ctrl_q.run && !wr |=> $stable(cnt_q.hi))
    else $error("high half ran while stopped");
  run_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_q.split && !ctrl_q.run && !wr |=> $stable(cnt_q))
    else $error("16-bit count moved while stopped");
  irq_lo_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && lo_wrap && ctrl_q.lien && ien_d[1] |=> irq)
    else $error("low wrap interrupt missing");
  irq_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && hi_wrap && ien_d[0] |=> irq)
    else $error("overflow interrupt missing");
  div12_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && tick12 |=> !tick12)
    else $error("divide by 12 ticked twice");
  cov_wrap16_c:  cover property (@(posedge pclk) !ctrl_q.split && hi_wrap);
  cov_split_c:   cover property (@(posedge pclk) ctrl_q.split && lo_wrap);
  cov_ext_c:     cover property (@(posedge pclk) ext_tick_q);
endmodule

// *** tb/auto_reload_timer_two_test.sv ***
// Purpose: Self-checking bench for the auto-reload timer two block
// Assumes: clk_en held high except during the freeze test; APB answers within 20 cycles
// Notes:   Tick phase is unknown, so divided counts use a window
`timescale 1ns/1ns
`include "art_regs.svh"
module auto_reload_timer_two_test;
  logic        pclk;
  logic        presetn;
  logic        clk_en;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        ext_osc;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          failures;
  int          checks_done;

  // Device under test
  art_timer dut_u
  (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ext_osc(ext_osc), .irq(irq)
  );

  // System clock, 100 MHz
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Oscillator runs free: one rising edge every four system clocks
  initial
  begin
    ext_osc = 1'b0;
    forever
    begin
      repeat (2) @(posedge pclk);
      ext_osc <= ~ext_osc;
    end
  end

  // Compare and count
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Look at the answer mid-cycle, where it is settled
    @(negedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(negedge pclk);
      n++;
    end
    if (n >= 20)
    begin
      failures++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    // Release only after the edge that samples pready high
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Bounded wait on the interrupt level
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq !== lvl && n < 2000)
    begin
      @(negedge pclk);
      n++;
    end
    if (n >= 2000)
    begin
      failures++;
      close_out();
    end
  endtask

  // Main sequence
  initial
  begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    failures = 0;
    checks_done = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `ART_OFS_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h0);
    apb(0, `ART_OFS_CNT_HI, 32'h0);
    check("count high reset", rd, 32'h0);
    $display("Test reset done");
    // Full 16-bit wrap with both overflow interrupts enabled
    apb(1, `ART_OFS_CLKCFG, 32'h3);
    apb(1, `ART_OFS_RLD_LO, 32'hF0);
    apb(1, `ART_OFS_RLD_HI, 32'h12);
    apb(1, `ART_OFS_CNT_LO, 32'h80);
    apb(1, `ART_OFS_CNT_HI, 32'hFF);
    apb(1, `ART_OFS_IRQ_EN, 32'h3);
    apb(1, `ART_OFS_CTRL, 32'h24);
    wait_irq(1'b1);
    apb(0, `ART_OFS_CNT_HI, 32'h0);
    check("reload high", rd, 32'h12);
    apb(0, `ART_OFS_IRQ_STAT, 32'h0);
    check("irq status", rd, 32'h3);
    // Stop but keep flags: they must not clear by themselves
    apb(1, `ART_OFS_CTRL, 32'hE0);
    repeat (50) @(posedge pclk);
    apb(0, `ART_OFS_CTRL, 32'h0);
    check("flags sticky", rd, 32'hE0);
    apb(1, `ART_OFS_CTRL, 32'h0);
    apb(1, `ART_OFS_IRQ_CLR, 32'h3);
    wait_irq(1'b0);
    $display("Test wrap16 done");
    // Split: low runs without run bit, high halted
    apb(1, `ART_OFS_CNT_HI, 32'h55);
    apb(1, `ART_OFS_RLD_LO, 32'hC0);
    apb(1, `ART_OFS_CNT_LO, 32'hF0);
    apb(1, `ART_OFS_CTRL, 32'h08);
    repeat (40) @(posedge pclk);
    apb(0, `ART_OFS_CNT_HI, 32'h0);
    check("high halted", rd, 32'h55);
    apb(0, `ART_OFS_CTRL, 32'h0);
    check("low flag only", rd, 32'h48);
    apb(0, `ART_OFS_CNT_LO, 32'h0);
    check("low reload", {31'h0, rd >= 32'hC0 && rd <= 32'hFF}, 32'h1);
    apb(0, `ART_OFS_IRQ_STAT, 32'h0);
    check("no low irq", rd, 32'h0);
    apb(1, `ART_OFS_CNT_HI, 32'hFE);
    apb(1, `ART_OFS_CTRL, 32'h0C);
    wait_irq(1'b1);
    // Stop the high half at once: it keeps counting after its reload
    apb(1, `ART_OFS_CTRL, 32'h08);
    apb(0, `ART_OFS_IRQ_STAT, 32'h0);
    check("high irq", rd, 32'h1);
    apb(0, `ART_OFS_CNT_HI, 32'h0);
    check("high reload", {31'h0, rd >= 32'h12 && rd <= 32'h16}, 32'h1);
    apb(1, `ART_OFS_CTRL, 32'h0);
    apb(1, `ART_OFS_IRQ_CLR, 32'h3);
    $display("Test split done");
    // Divided clocks: system/12 then external/8, about 20 ticks each
    for (int m = 0; m < 2; m++)
    begin
      apb(1, `ART_OFS_CLKCFG, 32'h0);
      apb(1, `ART_OFS_CTRL, m ? 32'h09 : 32'h08);
      apb(1, `ART_OFS_CNT_LO, 32'h0);
      repeat (m ? 640 : 240) @(posedge pclk);
      apb(0, `ART_OFS_CNT_LO, 32'h0);
      check("divided count", {31'h0, rd >= 18 && rd <= 22}, 32'h1);
    end
    $display("Test dividers done");
    // Freeze: 100 cycles with clk_en low must not advance the count
    apb(1, `ART_OFS_CLKCFG, 32'h1);
    apb(1, `ART_OFS_CTRL, 32'h0);
    apb(1, `ART_OFS_CNT_LO, 32'h0);
    apb(1, `ART_OFS_CTRL, 32'h04);
    @(posedge pclk);
    clk_en <= 1'b0;
    repeat (100) @(posedge pclk);
    clk_en <= 1'b1;
    apb(1, `ART_OFS_CTRL, 32'h0);
    apb(0, `ART_OFS_CNT_LO, 32'h0);
    check("frozen count", {31'h0, rd <= 32'h8}, 32'h1);
    $display("Test freeze done");
    // Unmapped address is refused
    apb(0, 12'h040, 32'h0);
    check("unmapped data", rd, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    $display("Test unmapped done");
    close_out();
  end
endmodule
